// ---- ieg_top.sv ----
// Interrupt gate words 0 and 1 with flags, behind an AXI4-Lite slave
//
// Function
// - A gate bit at one lets its source's request through, at zero blocks it.
// - Bit 15 of word 0 is absent, reads zero and ignores writes.
// - Bit 2 of word 1 is absent, reads zero and ignores writes.
// - Transfer-done gates sit at word 0 bits 4 and 14 and word 1 bit 8.
// - Serial 1 transmit/receive at word 0 bits 12/11, serial 2 at word 1 bits 15/14.
// - Timers 1, 2, 3 at word 0 bits 3, 7, 8; timers 4, 5 at word 1 bits 11, 12.
// - Compare 1, 2 at word 0 bits 2, 6; compare 3, 4 at word 1 bits 9, 10.
// - Capture 1, 2 at word 0 bits 1, 5; capture 7, 8 at word 1 bits 6, 7.
// - External pin 0 at word 0 bit 0; pins 1, 2 at word 1 bits 4, 13.
// - SPI port 1 event gate at word 0 bit 10 and error gate at bit 9.
// - Converter 1 done at word 0 bit 13, converter 2 done at word 1 bit 5.
// - Word 1 holds I2C master at bit 1, slave at bit 0, pin change at bit 3.
// - A flag bit reads one once its source requested, until a one is written to clear it.
`timescale 1ns/1ps
module ieg_top
    import ieg_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              nrst,

    // AXI4-Lite write address
    input  wire logic [IEG_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,

    // AXI4-Lite write data
    input  wire logic [IEG_DW-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,

    // AXI4-Lite write response
    output logic      [1:0]        s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,

    // AXI4-Lite read address
    input  wire logic [IEG_AW-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,

    // AXI4-Lite read data
    output logic      [IEG_DW-1:0] s_axi_rdata,
    output logic      [1:0]        s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,

    // Peripheral request lines
    input  wire logic [IEG_WW-1:0] src_req_w0,
    input  wire logic [IEG_WW-1:0] src_req_w1,

    // Gated requests to the priority logic
    output logic      [IEG_WW-1:0] gated_req_w0,
    output logic      [IEG_WW-1:0] gated_req_w1,
    output logic                   irq
);

    // Implemented bits of word 0
    localparam logic [IEG_WW-1:0] IMPL_W0 =
        (16'h0001 << XFER_CH0_DONE_GATE) |
        (16'h0001 << XFER_CH1_DONE_GATE) |
        (16'h0001 << SERIAL1_TRANSMIT_GATE) |
        (16'h0001 << SERIAL1_RECEIVE_GATE) |
        (16'h0001 << TIMER_ONE_GATE) |
        (16'h0001 << TIMER_TWO_GATE) |
        (16'h0001 << TIMER_THREE_GATE) |
        (16'h0001 << COMPARE_CH1_GATE) |
        (16'h0001 << COMPARE_CH2_GATE) |
        (16'h0001 << CAPTURE_CH1_GATE) |
        (16'h0001 << CAPTURE_CH2_GATE) |
        (16'h0001 << EXT_PIN0_GATE) |
        (16'h0001 << SPI_PORT1_EVENT_GATE) |
        (16'h0001 << SPI_PORT1_ERROR_GATE) |
        (16'h0001 << CONVERTER1_DONE_GATE);

    // Implemented bits of word 1
    localparam logic [IEG_WW-1:0] IMPL_W1 =
        (16'h0001 << XFER_CH2_DONE_GATE) |
        (16'h0001 << SERIAL2_TRANSMIT_GATE) |
        (16'h0001 << SERIAL2_RECEIVE_GATE) |
        (16'h0001 << TIMER_FOUR_GATE) |
        (16'h0001 << TIMER_FIVE_GATE) |
        (16'h0001 << COMPARE_CH3_GATE) |
        (16'h0001 << COMPARE_CH4_GATE) |
        (16'h0001 << CAPTURE_CH7_GATE) |
        (16'h0001 << CAPTURE_CH8_GATE) |
        (16'h0001 << EXT_PIN1_GATE) |
        (16'h0001 << EXT_PIN2_GATE) |
        (16'h0001 << CONVERTER2_DONE_GATE) |
        (16'h0001 << I2C_PORT1_MASTER_GATE) |
        (16'h0001 << I2C_PORT1_SLAVE_GATE) |
        (16'h0001 << PIN_CHANGE_NOTIFY_GATE);

    // Both masks, indexed by word
    localparam logic [IEG_NW-1:0][IEG_WW-1:0] IMPL = {IMPL_W1, IMPL_W0};

    // Address decode shared by the write and read paths
    function automatic ieg_sel_e decode(input logic [IEG_AW-1:0] a);
        ieg_sel_e s;
        s = IEG_SEL_NONE;
        if (a == IEG_OFF_GATE0) begin
            s = IEG_SEL_GATE0;
        end else if (a == IEG_OFF_GATE1) begin
            s = IEG_SEL_GATE1;
        end else if (a == IEG_OFF_FLAG0) begin
            s = IEG_SEL_FLAG0;
        end else if (a == IEG_OFF_FLAG1) begin
            s = IEG_SEL_FLAG1;
        end else if (a == IEG_OFF_PEND) begin
            s = IEG_SEL_PEND;
        end
        return s;
    endfunction

    // Write channel state
    logic              awready_reg;
    logic              awready_next;
    logic              wready_reg;
    logic              wready_next;
    logic              aw_hold_reg;
    logic              aw_hold_next;
    logic              w_hold_reg;
    logic              w_hold_next;
    logic              bvalid_reg;
    logic              bvalid_next;
    logic [1:0]        bresp_reg;
    logic [IEG_AW-1:0] awaddr_reg;
    logic [IEG_WW-1:0] wdata_reg;
    logic [1:0]        wstrb_reg;
    logic              aw_take;
    logic              w_take;
    logic              do_wr;
    ieg_sel_e          wsel;

    // Read channel state
    logic              arready_reg;
    logic              arready_next;
    logic              rvalid_reg;
    logic              rvalid_next;
    logic [1:0]        rresp_reg;
    logic [IEG_DW-1:0] rdata_reg;
    logic [IEG_DW-1:0] rd_word;
    logic [1:0]        rd_resp;
    logic              ar_take;

    // Word and forwarding signals
    logic [IEG_NW-1:0][IEG_WW-1:0] gate_w;
    logic [IEG_NW-1:0][IEG_WW-1:0] flag_w;
    logic [IEG_NW-1:0][IEG_WW-1:0] req_w;
    logic [IEG_NW-1:0]             wr_gate;
    logic [IEG_NW-1:0]             wr_clr;

    // Handshake events
    assign aw_take = s_axi_awvalid & awready_reg;
    assign w_take  = s_axi_wvalid & wready_reg;
    assign ar_take = s_axi_arvalid & arready_reg;
    assign do_wr   = aw_hold_reg & w_hold_reg & ~bvalid_reg;
    assign wsel    = decode(awaddr_reg);

    // Write channel next state; address and data in either order
    always_comb begin
        aw_hold_next = aw_hold_reg;
        w_hold_next  = w_hold_reg;
        bvalid_next  = bvalid_reg;
        if (aw_take) begin
            aw_hold_next = 1'b1;
        end else if (do_wr) begin
            aw_hold_next = 1'b0;
        end
        if (w_take) begin
            w_hold_next = 1'b1;
        end else if (do_wr) begin
            w_hold_next = 1'b0;
        end
        if (do_wr) begin
            bvalid_next = 1'b1;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        awready_next = ~aw_hold_next & ~bvalid_next;
        wready_next  = ~w_hold_next & ~bvalid_next;
    end

    // Write handshake flags
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
        end else begin
            aw_hold_reg <= aw_hold_next;
            w_hold_reg  <= w_hold_next;
            bvalid_reg  <= bvalid_next;
            awready_reg <= awready_next;
            wready_reg  <= wready_next;
        end
    end

    // Captured write address
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            awaddr_reg <= IEG_OFF_GATE0;
        end else if (aw_take) begin
            awaddr_reg <= s_axi_awaddr;
        end
    end

    // Captured write data; upper half and lanes are ignored
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wdata_reg <= IEG_GATE_RST;
            wstrb_reg <= 2'b00;
        end else if (w_take) begin
            wdata_reg <= s_axi_wdata[IEG_WW-1:0];
            wstrb_reg <= s_axi_wstrb[1:0];
        end
    end

    // Write response; unmapped addresses answer with an error
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bresp_reg <= IEG_RESP_OKAY;
        end else if (do_wr && wsel == IEG_SEL_NONE) begin
            bresp_reg <= IEG_RESP_SLVERR;
        end else if (do_wr) begin
            bresp_reg <= IEG_RESP_OKAY;
        end
    end

    // Write strobes into the words
    assign wr_gate[0] = do_wr & (wsel == IEG_SEL_GATE0);
    assign wr_gate[1] = do_wr & (wsel == IEG_SEL_GATE1);
    assign wr_clr[0]  = do_wr & (wsel == IEG_SEL_FLAG0);
    assign wr_clr[1]  = do_wr & (wsel == IEG_SEL_FLAG1);

    // Request lines per word
    assign req_w[0] = src_req_w0;
    assign req_w[1] = src_req_w1;

    // The two gate words
    ieg_word_if wif[IEG_NW] ();

    // One gate word per index
    genvar g;
    generate
        for (g = 0; g < IEG_NW; g++) begin : g_word
            assign wif[g].wr_gate = wr_gate[g];
            assign wif[g].wr_clr  = wr_clr[g];
            assign wif[g].wdata   = wdata_reg;
            assign wif[g].wstrb   = wstrb_reg;
            assign wif[g].req     = req_w[g];
            assign gate_w[g]      = wif[g].gate;
            assign flag_w[g]      = wif[g].flag;

            ieg_gate_word #(
                .IMPL (IMPL[g])
            ) u_word (
                .clk  (clk),
                .nrst (nrst),
                .w    (wif[g])
            );
        end
    endgenerate

    // Gated requests and interrupt
    ieg_fwd u_fwd (
        .clk    (clk),
        .nrst   (nrst),
        .gate0  (gate_w[0]),
        .flag0  (flag_w[0]),
        .gate1  (gate_w[1]),
        .flag1  (flag_w[1]),
        .gated0 (gated_req_w0),
        .gated1 (gated_req_w1),
        .irq    (irq)
    );

    // Read data selection
    // Pending word trails flag and gate by one clock
    always_comb begin
        rd_word = IEG_RDATA_RST;
        rd_resp = IEG_RESP_OKAY;
        case (decode(s_axi_araddr))
            IEG_SEL_GATE0: rd_word[IEG_WW-1:0] = gate_w[0];
            IEG_SEL_GATE1: rd_word[IEG_WW-1:0] = gate_w[1];
            IEG_SEL_FLAG0: rd_word[IEG_WW-1:0] = flag_w[0];
            IEG_SEL_FLAG1: rd_word[IEG_WW-1:0] = flag_w[1];
            IEG_SEL_PEND:  rd_word = {gated_req_w1, gated_req_w0};
            default:       rd_resp = IEG_RESP_SLVERR;
        endcase
    end

    // Read channel next state
    always_comb begin
        rvalid_next = rvalid_reg;
        if (ar_take) begin
            rvalid_next = 1'b1;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        arready_next = ~rvalid_next;
    end

    // Read handshake flags
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b0;
        end else begin
            rvalid_reg  <= rvalid_next;
            arready_reg <= arready_next;
        end
    end

    // Read data and response, held until taken
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= IEG_RDATA_RST;
            rresp_reg <= IEG_RESP_OKAY;
        end else if (ar_take) begin
            rdata_reg <= rd_word;
            rresp_reg <= rd_resp;
        end
    end

    // Bus outputs from registers
    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;

endmodule

// ---- ieg_pkg.sv ----
// Package of constants and types for the interrupt gate words 0 and 1
package ieg_pkg;

    // Bus and word widths
    localparam int IEG_AW = 8;
    localparam int IEG_DW = 32;
    localparam int IEG_WW = 16;
    localparam int IEG_NW = 2;

    // Register byte offsets
    localparam logic [IEG_AW-1:0] IEG_OFF_GATE0 = 8'h00;
    localparam logic [IEG_AW-1:0] IEG_OFF_GATE1 = 8'h04;
    localparam logic [IEG_AW-1:0] IEG_OFF_FLAG0 = 8'h08;
    localparam logic [IEG_AW-1:0] IEG_OFF_FLAG1 = 8'h0c;
    localparam logic [IEG_AW-1:0] IEG_OFF_PEND  = 8'h10;

    // Bus responses and reset values
    localparam logic [1:0]        IEG_RESP_OKAY   = 2'b00;
    localparam logic [1:0]        IEG_RESP_SLVERR = 2'b10;
    localparam logic [IEG_WW-1:0] IEG_GATE_RST    = 16'h0000;
    localparam logic [IEG_WW-1:0] IEG_FLAG_RST    = 16'h0000;
    localparam logic [IEG_DW-1:0] IEG_RDATA_RST   = 32'h0000_0000;

    // Field positions of gate word 0
    localparam int EXT_PIN0_GATE        = 0;
    localparam int CAPTURE_CH1_GATE     = 1;
    localparam int COMPARE_CH1_GATE     = 2;
    localparam int TIMER_ONE_GATE       = 3;
    localparam int XFER_CH0_DONE_GATE   = 4;
    localparam int CAPTURE_CH2_GATE     = 5;
    localparam int COMPARE_CH2_GATE     = 6;
    localparam int TIMER_TWO_GATE       = 7;
    localparam int TIMER_THREE_GATE     = 8;
    localparam int SPI_PORT1_ERROR_GATE = 9;
    localparam int SPI_PORT1_EVENT_GATE = 10;
    localparam int SERIAL1_RECEIVE_GATE = 11;
    localparam int SERIAL1_TRANSMIT_GATE = 12;
    localparam int CONVERTER1_DONE_GATE = 13;
    localparam int XFER_CH1_DONE_GATE   = 14;

    // Field positions of gate word 1
    localparam int I2C_PORT1_SLAVE_GATE   = 0;
    localparam int I2C_PORT1_MASTER_GATE  = 1;
    localparam int PIN_CHANGE_NOTIFY_GATE = 3;
    localparam int EXT_PIN1_GATE          = 4;
    localparam int CONVERTER2_DONE_GATE   = 5;
    localparam int CAPTURE_CH7_GATE       = 6;
    localparam int CAPTURE_CH8_GATE       = 7;
    localparam int XFER_CH2_DONE_GATE     = 8;
    localparam int COMPARE_CH3_GATE       = 9;
    localparam int COMPARE_CH4_GATE       = 10;
    localparam int TIMER_FOUR_GATE        = 11;
    localparam int TIMER_FIVE_GATE        = 12;
    localparam int EXT_PIN2_GATE          = 13;
    localparam int SERIAL2_RECEIVE_GATE   = 14;
    localparam int SERIAL2_TRANSMIT_GATE  = 15;

    // Register selected by an address
    typedef enum logic [2:0] {
        IEG_SEL_NONE,
        IEG_SEL_GATE0,
        IEG_SEL_GATE1,
        IEG_SEL_FLAG0,
        IEG_SEL_FLAG1,
        IEG_SEL_PEND
    } ieg_sel_e;

endpackage

// ---- ieg_word_if.sv ----
// Interface between the core and one gate/flag word
`timescale 1ns/1ps
interface ieg_word_if;
    import ieg_pkg::*;

    logic              wr_gate;
    logic              wr_clr;
    logic [IEG_WW-1:0] wdata;
    logic [1:0]        wstrb;
    logic [IEG_WW-1:0] req;
    logic [IEG_WW-1:0] gate;
    logic [IEG_WW-1:0] flag;

    // Core side drives writes and requests
    modport core (output wr_gate, wr_clr, wdata, wstrb, req, input gate, flag);
    // Word side holds the bits
    modport word (input wr_gate, wr_clr, wdata, wstrb, req, output gate, flag);
endinterface

// ---- ieg_gate_word.sv ----
// One 16-bit gate word with its matching sticky flag word
`timescale 1ns/1ps
module ieg_gate_word
    import ieg_pkg::*;
#(
    parameter logic [IEG_WW-1:0] IMPL = 16'hffff
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register and request side
    ieg_word_if.word w
);

    logic [IEG_WW-1:0] lane_mask;
    logic [IEG_WW-1:0] clr_mask;
    logic [IEG_WW-1:0] gate_reg;
    logic [IEG_WW-1:0] flag_reg;

    // Byte lanes and write-one-to-clear bits
    assign lane_mask = {{8{w.wstrb[1]}}, {8{w.wstrb[0]}}};
    assign clr_mask  = w.wr_clr ? (w.wdata & lane_mask) : IEG_FLAG_RST;

    // Gate bits; absent bits stay zero and ignore writes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gate_reg <= IEG_GATE_RST;
        end else if (w.wr_gate) begin
            gate_reg <= ((gate_reg & ~lane_mask) | (w.wdata & lane_mask)) & IMPL;
        end
    end

    // Sticky flags; a request in the clearing cycle wins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flag_reg <= IEG_FLAG_RST;
        end else begin
            flag_reg <= ((flag_reg & ~clr_mask) | w.req) & IMPL;
        end
    end

    assign w.gate = gate_reg;
    assign w.flag = flag_reg;

endmodule

// ---- ieg_fwd.sv ----
// Forwarding of gated requests and the summary interrupt
`timescale 1ns/1ps
module ieg_fwd
    import ieg_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              nrst,
    // Gate and flag words
    input  wire logic [IEG_WW-1:0] gate0,
    input  wire logic [IEG_WW-1:0] flag0,
    input  wire logic [IEG_WW-1:0] gate1,
    input  wire logic [IEG_WW-1:0] flag1,
    // Gated requests and interrupt
    output logic      [IEG_WW-1:0] gated0,
    output logic      [IEG_WW-1:0] gated1,
    output logic                   irq
);

    // A request passes only while flag and gate are both set
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gated0 <= IEG_FLAG_RST;
            gated1 <= IEG_FLAG_RST;
        end else begin
            gated0 <= flag0 & gate0;
            gated1 <= flag1 & gate1;
        end
    end

    // Level interrupt while any gated request stands
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |{flag0 & gate0, flag1 & gate1};
        end
    end

endmodule

// ---- ieg_top_chk.sv ----
// Checker of bus handshakes and request forwarding
`timescale 1ns/1ps
module ieg_top_chk
    import ieg_pkg::*;
(
    // Clock and reset
    input wire logic              clk,
    input wire logic              nrst,
    // Bus handshakes
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [IEG_DW-1:0] s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    // Gated requests
    input wire logic [IEG_WW-1:0] gated_req_w0,
    input wire logic [IEG_WW-1:0] gated_req_w1,
    input wire logic              irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // Address and data of a write taken at one edge
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Response at the second edge after the write is taken, inputs closed then
    sequence s_wr_answer;
        !s_axi_bvalid ##1 (s_axi_bvalid && !s_axi_awready && !s_axi_wready);
    endsequence

    // Bus timing and holding
    a_wr_answer: assert property (s_wr_both |=> s_wr_answer)
        else $error("write response late");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data changed early");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address open early");
    a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == IEG_RESP_SLVERR
        |-> s_axi_rdata == IEG_RDATA_RST)
        else $error("error read returned data");
    // Request forwarding
    a_irq_any: assert property (irq == |{gated_req_w1, gated_req_w0})
        else $error("interrupt differs from gated");
    a_gate_holes: assert property (!gated_req_w0[15] && !gated_req_w1[2])
        else $error("absent bit forwarded");
    a_gated_keep: assert property (!$rose(s_axi_bvalid) |=>
        ((gated_req_w0 & $past(gated_req_w0)) == $past(gated_req_w0))
        && ((gated_req_w1 & $past(gated_req_w1)) == $past(gated_req_w1)))
        else $error("gated request dropped");
endmodule

bind ieg_top ieg_top_chk u_chk (.clk(clk), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .gated_req_w0(gated_req_w0), .gated_req_w1(gated_req_w1), .irq(irq));

// ---- ieg_periph_model.sv ----
// Model of the peripheral request sources
`timescale 1ns/1ps
module ieg_periph_model
    import ieg_pkg::*;
(
    // Clock
    input  wire logic              clk,
    // Request lines out
    output logic      [IEG_WW-1:0] src_req_w0,
    output logic      [IEG_WW-1:0] src_req_w1
);

    // Sources idle low from the start
    initial begin
        src_req_w0 = 16'h0000;
        src_req_w1 = 16'h0000;
    end

    // One-cycle request pulse launched just after an edge
    task automatic fire(input logic [IEG_WW-1:0] m0, input logic [IEG_WW-1:0] m1);
        src_req_w0 <= m0;
        src_req_w1 <= m1;
        @(posedge clk);
        src_req_w0 <= 16'h0000;
        src_req_w1 <= 16'h0000;
    endtask
endmodule

// ---- test_interrupt_enable_words_0_1.sv ----
// Self-checking bench for the interrupt gate words
`timescale 1ns/1ps
module test_interrupt_enable_words_0_1
    import ieg_pkg::*;
();
    localparam logic [15:0] IMPL0 = 16'h7fff;
    localparam logic [15:0] IMPL1 = 16'hfffb;
    logic              clk, nrst, awvalid, wvalid, bready, arvalid, rready;
    logic              awready, wready, bvalid, arready, rvalid, irq;
    logic [IEG_AW-1:0] awaddr, araddr;
    logic [31:0]       wdata, rdata;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp;
    logic [15:0]       req0, req1, gtd0, gtd1, b, nb;
    logic [15:0]       g_m [2];
    logic [15:0]       f_m [2];
    int                n_fail, checks;

    ieg_top dut (.clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .src_req_w0(req0), .src_req_w1(req1), .gated_req_w0(gtd0), .gated_req_w1(gtd1),
        .irq(irq));
    ieg_periph_model per (.clk(clk), .src_req_w0(req0), .src_req_w1(req1));

    // Comparisons
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] got);
        checks++;
        if (got !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, e, got);
        end
    endtask
    task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] got);
        chk(nm, {30'h0, e}, {30'h0, got});
    endtask

    // Bus write with model update
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [15:0] lm;
        logic [1:0]  er;
        bit          aw_ok, w_ok;
        lm = {{8{s[1]}}, {8{s[0]}}};
        er = IEG_RESP_OKAY;
        aw_ok = 0;
        w_ok = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        case (a)
            IEG_OFF_GATE0: g_m[0] = ((g_m[0] & ~lm) | (d[15:0] & lm)) & IMPL0;
            IEG_OFF_GATE1: g_m[1] = ((g_m[1] & ~lm) | (d[15:0] & lm)) & IMPL1;
            IEG_OFF_FLAG0: f_m[0] = f_m[0] & ~(d[15:0] & lm);
            IEG_OFF_FLAG1: f_m[1] = f_m[1] & ~(d[15:0] & lm);
            IEG_OFF_PEND: ;
            default: er = IEG_RESP_SLVERR;
        endcase
        chk_resp("bresp", er, bresp);
    endtask

    // Bus read compared with the model
    task automatic rd(input logic [7:0] a);
        logic [31:0] e;
        logic [1:0]  er;
        er = IEG_RESP_OKAY;
        case (a)
            IEG_OFF_GATE0: e = {16'h0000, g_m[0]};
            IEG_OFF_GATE1: e = {16'h0000, g_m[1]};
            IEG_OFF_FLAG0: e = {16'h0000, f_m[0]};
            IEG_OFF_FLAG1: e = {16'h0000, f_m[1]};
            IEG_OFF_PEND: e = {g_m[1] & f_m[1], g_m[0] & f_m[0]};
            default: begin
                e = 32'h0000_0000;
                er = IEG_RESP_SLVERR;
            end
        endcase
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        chk("rdata", e, rdata);
        chk_resp("rresp", er, rresp);
    endtask

    // All registers, then the gated outputs
    task automatic rd_all;
        rd(IEG_OFF_GATE0);
        rd(IEG_OFF_GATE1);
        rd(IEG_OFF_FLAG0);
        rd(IEG_OFF_FLAG1);
        rd(IEG_OFF_PEND);
    endtask
    task automatic settle;
        repeat (2) @(posedge clk);
        chk("gated0", {16'h0000, g_m[0] & f_m[0]}, {16'h0000, gtd0});
        chk("gated1", {16'h0000, g_m[1] & f_m[1]}, {16'h0000, gtd1});
        chk("irq", {31'h0, |{g_m[1] & f_m[1], g_m[0] & f_m[0]}}, {31'h0, irq});
    endtask
    task automatic fire(input logic [15:0] m0, input logic [15:0] m1);
        per.fire(m0, m1);
        f_m[0] = f_m[0] | (m0 & IMPL0);
        f_m[1] = f_m[1] | (m1 & IMPL1);
        settle();
    endtask

    task automatic end_sim;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        end_sim();
    end

    // Main sequence
    initial begin
        {nrst, awvalid, wvalid, arvalid} = '0;
        {bready, rready} = 2'b11;
        {awaddr, araddr, wdata, wstrb} = '0;
        g_m = '{16'h0000, 16'h0000};
        f_m = '{16'h0000, 16'h0000};
        n_fail = 0;
        checks = 0;
        void'($urandom(58));
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd_all();
        $display("test reset done");
        wr(IEG_OFF_GATE0, 32'hffff_ffff, 4'hf);
        wr(IEG_OFF_GATE1, 32'hffff_ffff, 4'hf);
        fire(16'hffff, 16'hffff);
        rd_all();
        $display("test absent bits done");
        for (int w = 0; w < 2; w++) begin
            for (int i = 0; i < 16; i++) begin
                b = 16'h0001 << i;
                nb = 16'h0001 << ((i + 1) % 16);
                wr(w ? IEG_OFF_GATE1 : IEG_OFF_GATE0, {16'h0000, b}, 4'h3);
                wr(w ? IEG_OFF_FLAG1 : IEG_OFF_FLAG0, 32'h0000_ffff, 4'h3);
                fire(w ? 16'h0000 : b | nb, w ? b | nb : 16'h0000);
                rd(IEG_OFF_PEND);
            end
        end
        $display("test field positions done");
        repeat (20) begin
            wr(IEG_OFF_GATE0, $urandom, 4'($urandom));
            wr(IEG_OFF_GATE1, $urandom, 4'($urandom));
            fire(16'($urandom), 16'($urandom));
            rd_all();
            wr(IEG_OFF_FLAG0, $urandom, 4'hf);
            wr(IEG_OFF_FLAG1, $urandom, 4'hf);
            settle();
        end
        $display("test random traffic done");
        wr(8'h14, 32'hffff_ffff, 4'hf);
        rd(8'h14);
        wr(IEG_OFF_PEND, 32'hffff_ffff, 4'hf);
        rd(IEG_OFF_PEND);
        $display("test bus errors done");
        wr(IEG_OFF_GATE0, 32'hffff_ffff, 4'hf);
        fire(16'h7fff, 16'hfffb);
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        g_m = '{16'h0000, 16'h0000};
        f_m = '{16'h0000, 16'h0000};
        @(posedge clk);
        rd_all();
        settle();
        $display("test second reset done");
        end_sim();
    end
endmodule
